/* File: enc_latch_map.svh */
`ifndef ENC_LATCH_MAP_SVH
`define ENC_LATCH_MAP_SVH

// counter and preset value after reset
`define ENC_CNT_RST 32'h0000_0000
`define ENC_PRESET_DEFAULT 32'h0000_0000
// measurement mode codes
`define ENC_MODE_BOTH_UP 3'h0
`define ENC_MODE_BOTH_DN 3'h1
`define ENC_MODE_HIGH_UP 3'h2
`define ENC_MODE_HIGH_DN 3'h3
`define ENC_MODE_LOW_UP 3'h4
`define ENC_MODE_LOW_DN 3'h5
// mode field: bit 0 selects counting down
`define ENC_MODE_DIR_BIT 0

`endif

/* File: enc_latch_pkg.sv */
package enc_latch_pkg;

  typedef struct packed {
    logic inc;
    logic dec;
  } enc_step_t;

  typedef struct packed {
    logic latchIndexEn;
    logic latchRiseEn;
    logic latchFallEn;
    logic presetCmd;
    logic presetOnIndexEn;
    logic measureEn;
  } enc_ctrl_t;

  typedef struct packed {
    logic indexResetEn;
    logic extResetEn;
    logic extResetRising;
    logic [2:0] measureMode;
  } enc_cfg_t;

  typedef struct packed {
    logic indexLatchValid;
    logic extLatchValid;
    logic presetDone;
    logic measureDone;
  } enc_status_t;

  typedef enum logic [1:0] {
    M_IDLE,
    M_WAIT,
    M_FILT,
    M_DONE
  } meas_state_t;

endpackage : enc_latch_pkg

/* File: encoder_latch_reference_control.sv */
// Overview of operation
// - with index latch armed, first index rising edge captures; later ones ignored
// - an index capture sets the index-latch-valid flag
// - a re-armed latch captures only while both valid flags are false
// - with both latches armed, the first qualifying edge of either captures
// - index latch plus preset-on-index: capture old count, then load preset
// - index reset enabled: counter held at zero while index is high
// - external reset: zero on latch edge, rising if polarity set else falling
// - manual preset loads preset value into counter and sets preset-done
// - preset-on-index loads preset value at index pulse, sets preset-done
// - a re-armed preset loads only while preset-done is false
// - preset-done clears only when both preset command bits are false
// - a 32-bit latch filter, counted in encoder increments
// - six measurement modes chosen by the measurement mode field
// - measurement starts when the measurement enable bit goes true
// - modes 0,1 both levels, 2,3 high, 4,5 low; odd modes count down
// - buffered start-edge count is stored only when the filter expires
// - a latch change inside the filter discards the buffer; rebuffer later
// - completion of a measurement sets the measurement-done flag
`timescale 1ns/100ps
`include "enc_latch_map.svh"

module encoder_latch_reference_control
  import enc_latch_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire enc_step_t encStep, // one-cycle count steps from decoder
  input wire logic indexIn, // encoder zero pulse, channel C
  input wire logic latchIn, // external latch input
  input wire enc_ctrl_t ctrl, // host command bits
  input wire enc_cfg_t cfg, // host configuration bits
  input wire logic [CNT_W-1:0] presetValue, // reference value for preset
  input wire logic [CNT_W-1:0] latchFilter, // filter length in increments
  output logic [CNT_W-1:0] counterValue, // position counter
  output logic [CNT_W-1:0] latchValue, // index / external latch value
  output logic [CNT_W-1:0] riseLatch, // measurement value, rising edge
  output logic [CNT_W-1:0] fallLatch, // measurement value, falling edge
  output enc_status_t status // valid and done flags
);

  if (CNT_W < 2 || CNT_W > 32) begin : g_width_check
    $error("CNT_W must lie between 2 and 32");
  end

  // ---------------- latch, preset and counter group
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] latch_reg, latch_next;
  logic idxPrev_reg, latPrev_reg;
  enc_ctrl_t ctrlPrev_reg;
  logic armIdx_reg, armIdx_next, armExt_reg, armExt_next;
  logic armPre_reg, armPre_next;
  logic idxValid_reg, idxValid_next, extValid_reg, extValid_next;
  logic preDone_reg, preDone_next;
  logic idxRise, latRise, latFall, extEn, extEdge, freeLatch;
  logic capIdx, capExt, loadMan, loadIdx, resetNow, swapDir;
  meas_state_t mState_reg, mState_next;

  always_comb begin
    idxRise = indexIn & ~idxPrev_reg;
    latRise = latchIn & ~latPrev_reg;
    latFall = ~latchIn & latPrev_reg;
    extEn = ctrl.latchRiseEn | ctrl.latchFallEn;
    extEdge = (ctrl.latchRiseEn & latRise) | (ctrl.latchFallEn & latFall);
    freeLatch = ~idxValid_reg & ~extValid_reg;
    capIdx = armIdx_reg & ctrl.latchIndexEn & idxRise & freeLatch;
    capExt = armExt_reg & extEn & extEdge & freeLatch & ~capIdx;
    loadMan = armPre_reg & ctrl.presetCmd & ~preDone_reg;
    loadIdx = armPre_reg & ctrl.presetOnIndexEn & idxRise
              & ~preDone_reg;
    // index reset takes precedence if the host enables both anyway
    resetNow = (cfg.indexResetEn & indexIn)
             | (cfg.extResetEn & ~cfg.indexResetEn
                & (cfg.extResetRising ? latRise : latFall));
    swapDir = (mState_reg != M_IDLE)
              & cfg.measureMode[`ENC_MODE_DIR_BIT];

    // the first capture of either source disarms both
    armIdx_next = armIdx_reg;
    if (capIdx || capExt) begin
      armIdx_next = 1'b0;
    end else if (ctrl.latchIndexEn && !ctrlPrev_reg.latchIndexEn) begin
      armIdx_next = 1'b1;
    end else if (!ctrl.latchIndexEn) begin
      armIdx_next = 1'b0;
    end
    armExt_next = armExt_reg;
    if (capIdx || capExt) begin
      armExt_next = 1'b0;
    end else if ((ctrl.latchRiseEn && !ctrlPrev_reg.latchRiseEn)
        || (ctrl.latchFallEn && !ctrlPrev_reg.latchFallEn)) begin
      armExt_next = 1'b1;
    end else if (!extEn) begin
      armExt_next = 1'b0;
    end

    // set wins over clear on both valid flags
    idxValid_next = capIdx | (idxValid_reg & ctrl.latchIndexEn);
    extValid_next = capExt | (extValid_reg & extEn);
    latch_next = (capIdx || capExt) ? cnt_reg : latch_reg;

    armPre_next = armPre_reg;
    if (loadMan || loadIdx) begin
      armPre_next = 1'b0;
    end else if ((ctrl.presetCmd && !ctrlPrev_reg.presetCmd)
        || (ctrl.presetOnIndexEn && !ctrlPrev_reg.presetOnIndexEn)) begin
      armPre_next = 1'b1;
    end else if (!ctrl.presetCmd && !ctrl.presetOnIndexEn) begin
      // a refused re-activation must not stay armed once both bits drop
      armPre_next = 1'b0;
    end
    preDone_next = loadMan | loadIdx
                 | (preDone_reg
                    & (ctrl.presetCmd | ctrl.presetOnIndexEn));

    // preset beats reset beats counting
    if (loadMan || loadIdx) begin
      cnt_next = presetValue;
    end else if (resetNow) begin
      cnt_next = '0;
    end else if (encStep.inc && !encStep.dec) begin
      cnt_next = swapDir ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
    end else if (encStep.dec && !encStep.inc) begin
      cnt_next = swapDir ? cnt_reg + 1'b1 : cnt_reg - 1'b1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= CNT_W'(`ENC_CNT_RST);
      latch_reg <= CNT_W'(`ENC_CNT_RST);
      idxPrev_reg <= 1'b0;
      latPrev_reg <= 1'b0;
      ctrlPrev_reg <= '0;
      armIdx_reg <= 1'b0;
      armExt_reg <= 1'b0;
      armPre_reg <= 1'b0;
      idxValid_reg <= 1'b0;
      extValid_reg <= 1'b0;
      preDone_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      latch_reg <= latch_next;
      idxPrev_reg <= indexIn;
      latPrev_reg <= latchIn;
      ctrlPrev_reg <= ctrl;
      armIdx_reg <= armIdx_next;
      armExt_reg <= armExt_next;
      armPre_reg <= armPre_next;
      idxValid_reg <= idxValid_next;
      extValid_reg <= extValid_next;
      preDone_reg <= preDone_next;
    end
  end

  // ---------------- workpiece measurement group
  logic [CNT_W-1:0] buf_reg, buf_next, filt_reg, filt_next;
  logic [CNT_W-1:0] rise_reg, rise_next, fall_reg, fall_next;
  logic endPhase_reg, endPhase_next, mDone_reg, mDone_next;
  logic modeOk, target, levelOk, expired, stepAny, lowOnly;

  always_comb begin
    modeOk = cfg.measureMode <= `ENC_MODE_LOW_DN;
    lowOnly = cfg.measureMode >= `ENC_MODE_LOW_UP;
    target = ~endPhase_reg & ~lowOnly;
    levelOk = latchIn == target;
    expired = filt_reg >= latchFilter;
    stepAny = encStep.inc ^ encStep.dec;
    mState_next = mState_reg;
    buf_next = buf_reg;
    filt_next = filt_reg;
    rise_next = rise_reg;
    fall_next = fall_reg;
    endPhase_next = endPhase_reg;
    mDone_next = mDone_reg & ctrl.measureEn;
    unique case (mState_reg)
      M_IDLE: begin
        if (ctrl.measureEn && !ctrlPrev_reg.measureEn && modeOk) begin
          mState_next = M_WAIT;
          endPhase_next = 1'b0;
          mDone_next = 1'b0;
        end
      end
      M_WAIT: begin
        if (levelOk) begin
          buf_next = cnt_reg;
          filt_next = '0;
          mState_next = M_FILT;
        end
      end
      M_FILT: begin
        if (!levelOk) begin
          mState_next = M_WAIT;
        end else if (expired) begin
          if (endPhase_reg || lowOnly) begin
            fall_next = buf_reg;
          end else begin
            rise_next = buf_reg;
          end
          if (!endPhase_reg && cfg.measureMode <= `ENC_MODE_BOTH_DN) begin
            endPhase_next = 1'b1;
            mState_next = M_WAIT;
          end else begin
            mDone_next = 1'b1;
            mState_next = M_DONE;
          end
        end else if (stepAny) begin
          filt_next = filt_reg + 1'b1;
        end
      end
      M_DONE: begin
      end
    endcase
    if (!ctrl.measureEn) begin
      mState_next = M_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mState_reg <= M_IDLE;
      buf_reg <= CNT_W'(`ENC_CNT_RST);
      filt_reg <= CNT_W'(`ENC_CNT_RST);
      rise_reg <= CNT_W'(`ENC_CNT_RST);
      fall_reg <= CNT_W'(`ENC_CNT_RST);
      endPhase_reg <= 1'b0;
      mDone_reg <= 1'b0;
    end else begin
      mState_reg <= mState_next;
      buf_reg <= buf_next;
      filt_reg <= filt_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      endPhase_reg <= endPhase_next;
      mDone_reg <= mDone_next;
    end
  end

  assign counterValue = cnt_reg;
  assign latchValue = latch_reg;
  assign riseLatch = rise_reg;
  assign fallLatch = fall_reg;
  assign status = '{indexLatchValid: idxValid_reg,
                    extLatchValid: extValid_reg,
                    presetDone: preDone_reg,
                    measureDone: mDone_reg};

  // ---------------- checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence filtExpire;
    mState_reg == M_FILT && levelOk && expired;
  endsequence

  sequence lastPhase;
    endPhase_reg || cfg.measureMode > `ENC_MODE_BOTH_DN;
  endsequence

  idx_capture_a: assert property (
    $rose(idxValid_reg) |-> latchValue == $past(cnt_reg)
      && $past(indexIn) && !$past(idxPrev_reg))
    else $error("index capture wrong");
  latch_held_a: assert property (
    (idxValid_reg || extValid_reg) |=> $stable(latch_reg))
    else $error("latch changed while a valid flag was set");
  ext_capture_a: assert property (
    $rose(extValid_reg) |-> $past(extEdge) && !idxValid_reg)
    else $error("external capture without edge");
  idx_preset_a: assert property (
    (capIdx && loadIdx) |=> latch_reg == $past(cnt_reg)
      && cnt_reg == $past(presetValue) && preDone_reg)
    else $error("capture and preset order wrong");
  idx_reset_a: assert property (
    (cfg.indexResetEn && indexIn && !loadMan && !loadIdx) |=> cnt_reg == '0)
    else $error("index reset missed");
  ext_reset_a: assert property (
    (cfg.extResetEn && !cfg.indexResetEn && !cfg.extResetRising
      && latFall && !loadMan && !loadIdx) |=> cnt_reg == '0)
    else $error("external reset missed");
  preset_load_a: assert property (
    $rose(ctrl.presetCmd) && !preDone_reg ##1 !preDone_reg
      && ctrl.presetCmd |=> cnt_reg == $past(presetValue) && preDone_reg)
    else $error("manual preset not applied");
  preset_once_a: assert property (
    preDone_reg && (ctrl.presetCmd || ctrl.presetOnIndexEn) && !resetNow
      && !encStep.inc && !encStep.dec |=> preDone_reg && $stable(cnt_reg))
    else $error("preset applied while preset-done was set");
  done_clear_a: assert property (
    (!ctrl.presetCmd && !ctrl.presetOnIndexEn) [*2] |-> !preDone_reg)
    else $error("preset-done not cleared");
  filt_store_a: assert property (
    filtExpire ##0 !endPhase_reg && !lowOnly
      |=> rise_reg == $past(buf_reg))
    else $error("rising value not stored at filter expiry");
  filt_discard_a: assert property (
    (mState_reg == M_FILT && !levelOk && ctrl.measureEn)
      |=> mState_reg == M_WAIT && $stable(rise_reg) && $stable(fall_reg))
    else $error("interference did not discard buffer");
  meas_done_a: assert property (
    filtExpire ##0 lastPhase ##0 ctrl.measureEn |=> mDone_reg
      ##0 mState_reg == M_DONE)
    else $error("measurement done not raised");

endmodule : encoder_latch_reference_control

/* File: encoder_latch_reference_control_tb.sv */
`timescale 1ns/100ps

module encoder_latch_reference_control_tb
  import enc_latch_pkg::*;
;
  typedef struct {
    logic [31:0] val;
    int n;
    logic [31:0] exp;
  } row_t;
  row_t rows [3] = '{'{32'h0000_0000, -1, 32'hffff_ffff},
    '{32'hffff_ffff, 1, 32'h0000_0000}, '{32'h1234_5678, 2, 32'h1234_567a}};
  logic sys_clk, rst_n, stepOn, stepDown, zeroPulse, latchLevel;
  logic indexIn, latchIn;
  enc_step_t encStep;
  enc_ctrl_t ctrl;
  enc_cfg_t cfg;
  enc_status_t status;
  logic [31:0] presetValue, latchFilter, counterValue, latchValue;
  logic [31:0] riseLatch, fallLatch, s, e;
  int fails = 0;
  int tests_run = 0;

  encoder_source src (.stepOn(stepOn), .stepDown(stepDown),
    .zeroPulse(zeroPulse), .latchLevel(latchLevel), .encStep(encStep),
    .indexIn(indexIn), .latchIn(latchIn));
  encoder_latch_reference_control #(.CNT_W(32)) DUT (.sys_clk(sys_clk),
    .rst_n(rst_n), .encStep(encStep), .indexIn(indexIn), .latchIn(latchIn),
    .ctrl(ctrl), .cfg(cfg), .presetValue(presetValue),
    .latchFilter(latchFilter), .counterValue(counterValue),
    .latchValue(latchValue), .riseLatch(riseLatch), .fallLatch(fallLatch),
    .status(status));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task look;
    @(negedge sys_clk);
  endtask : look
  task steps(input int n);
    @(posedge sys_clk);
    stepOn <= 1'b1;
    stepDown <= n < 0;
    tick(n < 0 ? -n : n);
    stepOn <= 1'b0;
  endtask : steps
  task pulse;
    @(posedge sys_clk);
    zeroPulse <= 1'b1;
    @(posedge sys_clk);
    zeroPulse <= 1'b0;
    tick(3);
    look;
  endtask : pulse
  task lat(input logic v);
    @(posedge sys_clk);
    latchLevel <= v;
    tick(3);
    look;
  endtask : lat
  task cmd(input enc_ctrl_t c);
    @(posedge sys_clk);
    ctrl <= c;
    tick(3);
    look;
  endtask : cmd
  task setp(input logic [31:0] v);
    @(posedge sys_clk);
    presetValue <= v;
    @(posedge sys_clk);
    ctrl.presetCmd <= 1'b1;
    tick(2);
    look;
  endtask : setp

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #400us;
    fails++;
    report_and_stop;
  end
  initial begin
    rst_n = 1'b0;
    stepOn = 1'b0;
    stepDown = 1'b0;
    zeroPulse = 1'b0;
    latchLevel = 1'b0;
    ctrl = '0;
    cfg = '0;
    presetValue = 32'h0000_0000;
    latchFilter = 32'h0000_0003;
    tick(11);
    look;
    check(counterValue | latchValue, 32'h0);
    check(32'(status), 32'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    look;
    check(riseLatch | fallLatch, 32'h0);
    check(32'(status), 32'h0);
    foreach (rows[i]) begin
      setp(rows[i].val);
      check(counterValue, rows[i].val);
      check(32'(status.presetDone), 32'h1);
      steps(rows[i].n);
      look;
      check(counterValue, rows[i].exp);
      cmd(6'h00);
      check(32'(status.presetDone), 32'h0);
    end
    // index and rising latch armed together, latch edge comes first
    cmd(6'h30);
    lat(1'b1);
    check(latchValue, 32'h1234_567a);
    check(32'(status), 32'h4);
    steps(3);
    pulse;
    check(latchValue, 32'h1234_567a);
    cmd(6'h10);
    cmd(6'h30);
    pulse;
    check(latchValue, 32'h1234_567a);
    cmd(6'h00);
    check(32'(status), 32'h0);
    lat(1'b0);
    cmd(6'h20);
    pulse;
    check(latchValue, 32'h1234_567d);
    check(32'(status), 32'h8);
    steps(2);
    pulse;
    check(latchValue, 32'h1234_567d);
    cmd(6'h00);
    @(posedge sys_clk);
    presetValue <= 32'h0000_0040;
    cmd(6'h22);
    pulse;
    check(latchValue, 32'h1234_567f);
    check(counterValue, 32'h0000_0040);
    check(32'(status), 32'ha);
    steps(2);
    pulse;
    check(counterValue, 32'h0000_0042);
    cmd(6'h26);
    check(counterValue, 32'h0000_0042);
    cmd(6'h04);
    check(32'(status.presetDone), 32'h1);
    cmd(6'h00);
    check(32'(status), 32'h0);
    @(posedge sys_clk);
    cfg.indexResetEn <= 1'b1;
    zeroPulse <= 1'b1;
    steps(2);
    look;
    check(counterValue, 32'h0);
    @(posedge sys_clk);
    zeroPulse <= 1'b0;
    cfg <= 6'h10;
    steps(3);
    lat(1'b1);
    check(counterValue, 32'h3);
    lat(1'b0);
    check(counterValue, 32'h0);
    @(posedge sys_clk);
    cfg <= 6'h18;
    steps(2);
    lat(1'b1);
    check(counterValue, 32'h0);
    for (int m = 0; m < 6; m++) begin
      setp(32'h0000_0100 + 32'(m * 16));
      cmd(6'h00);
      s = 32'h0000_0100 + 32'(m * 16) + 32'(m == 0);
      e = m[0] ? s - 32'h4 : s + 32'h4;
      @(posedge sys_clk);
      latchLevel <= m > 3;
      cfg <= {3'h0, 3'(m)};
      cmd(6'h01);
      lat(m < 4);
      if (m == 0) begin
        steps(1);
        @(posedge sys_clk);
        latchLevel <= 1'b0;
        @(posedge sys_clk);
        latchLevel <= 1'b1;
        tick(2);
      end
      steps(4);
      look;
      check(counterValue, e);
      if (m < 2) begin
        lat(1'b0);
        steps(4);
      end
      tick(3);
      look;
      if (m == 0) check(riseLatch, 32'h0000_0101);
      if (m < 4) check(riseLatch, s);
      if (m < 2) check(fallLatch, e);
      if (m > 3) check(fallLatch, s);
      check(32'(status.measureDone), 32'h1);
      cmd(6'h00);
      check(32'(status.measureDone), 32'h0);
    end
    // reset in mid-run clears every result and flag
    @(posedge sys_clk);
    rst_n <= 1'b0;
    look;
    check(counterValue | latchValue, 32'h0);
    check(riseLatch | fallLatch, 32'h0);
    check(32'(status), 32'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(1);
    look;
    check(counterValue | latchValue, 32'h0);
    report_and_stop;
  end
endmodule : encoder_latch_reference_control_tb

/* File: encoder_source.sv */
`timescale 1ns/100ps

module encoder_source
  import enc_latch_pkg::*;
(
  input wire logic stepOn, // one increment per cycle while high
  input wire logic stepDown, // direction of the increments
  input wire logic zeroPulse, // requested level on channel C
  input wire logic latchLevel, // requested external latch level
  output enc_step_t encStep, // decoded count steps
  output logic indexIn, // channel C
  output logic latchIn // external latch line
);
  assign encStep = '{inc: stepOn & ~stepDown, dec: stepOn & stepDown};
  assign indexIn = zeroPulse;
  assign latchIn = latchLevel;
endmodule : encoder_source
